// ### rtl/sbg_pkg.sv
// constants, types and helpers shared by the serial baud rate generator
// assumes a single 125 MHz system clock and an 8-bit register port
//
// Overview of operation
// - timer is 8-bit after reset, 16-bit when wide-divisor select is set
// - timer free-runs with period n+1; 8-bit mode uses only the low byte
// - async multiplier from high-speed and wide bits; sync ignores high-speed
// - async, 8-bit, low speed: rate is clock over 64 times (n+1)
// - async, 16-bit, low speed: rate is clock over 16 times (n+1)
// - sync, any width or speed bit: rate is clock over 4 times (n+1)
// - writing either divisor byte clears the timer at once
// - async 8-bit low speed: divisor 0 gives clock/64, divisor 2 clock/192
// - receive idle flag reads 1 when receiver idle, 0 once it is active
// - mode bit 1 selects synchronous; high-speed bit 1 selects high speed
package sbg_pkg;

  // ==========================================================
  // clock
  localparam int unsigned SYS_CLK_HZ = 125000000;

  // ==========================================================
  // register map, byte offsets on the plain port
  localparam int          ADDR_W        = 3;
  localparam logic [2:0]  OFS_TX_CTRL   = 3'h0;
  localparam logic [2:0]  OFS_RX_CTRL   = 3'h1;
  localparam logic [2:0]  OFS_BAUD_CTRL = 3'h2;
  localparam logic [2:0]  OFS_DIV_HIGH  = 3'h3;
  localparam logic [2:0]  OFS_DIV_LOW   = 3'h4;

  // ==========================================================
  // field positions
  localparam int TX_SYNC_BIT   = 4;
  localparam int TX_HIGH_BIT   = 2;
  localparam int TX_EMPTY_BIT  = 1;
  localparam int BC_IDLE_BIT   = 6;
  localparam int BC_WIDE_BIT   = 3;
  localparam int BC_RSVD_BIT   = 2;
  localparam int BC_OVF_BIT    = 7;

  // writable masks, other bits come from status or read as zero
  localparam logic [7:0] TX_WR_MASK = 8'hfd;
  localparam logic [7:0] RX_WR_MASK = 8'hf8;
  localparam logic [7:0] BC_WR_MASK = 8'h3b;

  // ==========================================================
  // reset values
  localparam logic [7:0] TX_CTRL_RST   = 8'h00;
  localparam logic [7:0] RX_CTRL_RST   = 8'h00;
  localparam logic [7:0] BAUD_CTRL_RST = 8'h00;
  localparam logic [7:0] DIV_HIGH_RST  = 8'h00;
  localparam logic [7:0] DIV_LOW_RST   = 8'h00;

  // ==========================================================
  // bit-period multipliers
  localparam logic [6:0] MULT_SLOW   = 7'h40;
  localparam logic [6:0] MULT_MID    = 7'h10;
  localparam logic [6:0] MULT_FAST   = 7'h04;
  localparam int         PERIOD_W    = 24;

  // ==========================================================
  // types
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wrData;
    logic              wrStb;
    logic              rdStb;
  } sbg_bus_req_t;

  typedef struct packed {
    logic       syncMode;
    logic       highSpeed;
    logic       wideDivisor;
    logic [15:0] divisor;
  } sbg_rate_cfg_t;

  // multiplier chosen by the mode bits
  function automatic logic [6:0] sbgMultiplier(input sbg_rate_cfg_t cfg);
    logic [6:0] m;
    m = MULT_FAST;
    if (!cfg.syncMode) begin
      case ({cfg.wideDivisor, cfg.highSpeed})
        2'b00:   m = MULT_SLOW;
        2'b01:   m = MULT_MID;
        2'b10:   m = MULT_MID;
        default: m = MULT_FAST;
      endcase
    end
    return m;
  endfunction : sbgMultiplier

  // divisor as the timer really uses it
  function automatic logic [15:0] sbgEffDivisor(input sbg_rate_cfg_t cfg);
    return cfg.wideDivisor ? cfg.divisor : {8'h00, cfg.divisor[7:0]};
  endfunction : sbgEffDivisor

endpackage : sbg_pkg

// ### rtl/sbg_divisor_timer.sv
// free-running divisor timer, overflows every n+1 clocks
// assumes clear and configuration come from the register block
`timescale 1ns/10ps
module sbg_divisor_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             clear,
  input  wire sbg_pkg::sbg_rate_cfg_t cfg,
  output logic                  overflow,
  output logic [WIDTH-1:0]      count
);
  import sbg_pkg::*;

  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] limit;

  assign limit    = sbgEffDivisor(cfg);
  assign overflow = !clear && (count_ff == limit);
  assign count    = count_ff;

  // ==========================================================
  // counter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_ff <= '0;
    end else if (clear || overflow) begin
      count_ff <= '0;
    end else if (!cfg.wideDivisor) begin
      count_ff <= {8'h00, count_ff[7:0] + 8'h01};
    end else begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  // ==========================================================
  // checks
  a_narrow_high_zero: assert property (@(posedge sys_clk) disable iff (rst)
    !cfg.wideDivisor |-> count_ff[15:8] == 8'h00)
    else $error("upper timer byte moved in 8-bit mode");

  a_clear_zeroes: assert property (@(posedge sys_clk) disable iff (rst)
    clear |=> count_ff == 16'h0000)
    else $error("timer not cleared after divisor write");

  a_count_bounded: assert property (@(posedge sys_clk) disable iff (rst)
    $stable(cfg) && !$past(clear) |-> count_ff <= limit)
    else $error("timer ran past divisor");

endmodule : sbg_divisor_timer

// ### rtl/sbg_rate_scaler.sv
// divides timer overflows by the mode multiplier into the bit-rate tick
// assumes step pulses come from the divisor timer
`timescale 1ns/10ps
module sbg_rate_scaler (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       step,
  input  wire logic [6:0] mult,
  output logic            tick
);
  import sbg_pkg::*;

  logic [6:0] phase_ff;
  logic       tick_ff;
  logic       wrap;

  assign wrap = step && (phase_ff >= mult - 7'h01);
  assign tick = tick_ff;

  // ==========================================================
  // phase counter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_ff <= '0;
    end else if (clear || wrap) begin
      phase_ff <= '0;
    end else if (step) begin
      phase_ff <= phase_ff + 7'h01;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= wrap && !clear;
    end
  end

endmodule : sbg_rate_scaler

// ### rtl/sbg_baud_gen.sv
// serial baud rate generator: registers, mode select, timer and scaler
// assumes the transceiver consumes baudTick and drives the status inputs
`timescale 1ns/10ps
module sbg_baud_gen (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire sbg_pkg::sbg_bus_req_t busReq,
  output logic [7:0]                 rdData,
  input  wire logic                  rxActive,
  input  wire logic                  txShiftEmpty,
  input  wire logic [2:0]            rxStatus,
  output logic [7:0]                 txControl,
  output logic [7:0]                 rxControl,
  output logic [7:0]                 baudControl,
  output logic                       syncMode,
  output logic                       baudTick
);
  import sbg_pkg::*;

  // ==========================================================
  // register state
  logic [7:0]    txCtrl_ff;
  logic [7:0]    rxCtrl_ff;
  logic [7:0]    baudCtrl_ff;
  logic [7:0]    divHigh_ff;
  logic [7:0]    divLow_ff;
  logic          rxIdle_ff;
  logic [7:0]    rdData_ff;
  logic [7:0]    nxt_rdData;
  logic          wrTx;
  logic          wrRx;
  logic          wrBaud;
  logic          wrDivHigh;
  logic          wrDivLow;
  logic          restart;
  sbg_rate_cfg_t cfg;
  logic [6:0]    mult;
  logic          timerOverflow;
  logic [15:0]   timerCount;

  assign wrTx      = busReq.wrStb && (busReq.addr == OFS_TX_CTRL);
  assign wrRx      = busReq.wrStb && (busReq.addr == OFS_RX_CTRL);
  assign wrBaud    = busReq.wrStb && (busReq.addr == OFS_BAUD_CTRL);
  assign wrDivHigh = busReq.wrStb && (busReq.addr == OFS_DIV_HIGH);
  assign wrDivLow  = busReq.wrStb && (busReq.addr == OFS_DIV_LOW);

  // a mode change also restarts, so no period mixes two settings
  assign restart = wrDivHigh || wrDivLow || wrTx || wrBaud;

  // ==========================================================
  // software-written registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txCtrl_ff <= TX_CTRL_RST;
    end else if (wrTx) begin
      txCtrl_ff <= busReq.wrData & TX_WR_MASK;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxCtrl_ff <= RX_CTRL_RST;
    end else if (wrRx) begin
      rxCtrl_ff <= busReq.wrData & RX_WR_MASK;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      baudCtrl_ff <= BAUD_CTRL_RST;
    end else if (wrBaud) begin
      baudCtrl_ff <= busReq.wrData & BC_WR_MASK;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      divHigh_ff <= DIV_HIGH_RST;
      divLow_ff  <= DIV_LOW_RST;
    end else begin
      if (wrDivHigh) begin
        divHigh_ff <= busReq.wrData;
      end
      if (wrDivLow) begin
        divLow_ff <= busReq.wrData;
      end
    end
  end

  // idle flag follows the receiver, registered once
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxIdle_ff <= 1'b1;
    end else begin
      rxIdle_ff <= !rxActive;
    end
  end

  // ==========================================================
  // read path: data valid only in the cycle after the strobe
  always_comb begin
    nxt_rdData = 8'h00;
    if (busReq.rdStb) begin
      case (busReq.addr)
        OFS_TX_CTRL: begin
          nxt_rdData               = txCtrl_ff;
          nxt_rdData[TX_EMPTY_BIT] = txShiftEmpty;
        end
        OFS_RX_CTRL: begin
          nxt_rdData = rxCtrl_ff | {5'h00, rxStatus};
        end
        OFS_BAUD_CTRL: begin
          nxt_rdData              = baudCtrl_ff;
          nxt_rdData[BC_IDLE_BIT] = rxIdle_ff;
          nxt_rdData[BC_OVF_BIT]  = 1'b0;
          nxt_rdData[BC_RSVD_BIT] = 1'b0;
        end
        OFS_DIV_HIGH: begin
          nxt_rdData = divHigh_ff;
        end
        OFS_DIV_LOW: begin
          nxt_rdData = divLow_ff;
        end
        default: begin
          nxt_rdData = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdData_ff <= 8'h00;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  // ==========================================================
  // rate configuration
  assign cfg.syncMode    = txCtrl_ff[TX_SYNC_BIT];
  assign cfg.highSpeed   = txCtrl_ff[TX_HIGH_BIT];
  assign cfg.wideDivisor = baudCtrl_ff[BC_WIDE_BIT];
  assign cfg.divisor     = {divHigh_ff, divLow_ff};
  assign mult            = sbgMultiplier(cfg);

  sbg_divisor_timer #(
    .WIDTH (16)
  ) u_timer (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clear    (restart),
    .cfg      (cfg),
    .overflow (timerOverflow),
    .count    (timerCount)
  );

  sbg_rate_scaler u_scaler (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clear   (restart),
    .step    (timerOverflow),
    .mult    (mult),
    .tick    (baudTick)
  );

  assign rdData      = rdData_ff;
  assign txControl   = txCtrl_ff;
  assign rxControl   = rxCtrl_ff;
  assign baudControl = baudCtrl_ff;
  assign syncMode    = txCtrl_ff[TX_SYNC_BIT];

  // ==========================================================
  // period checking helpers
  logic [PERIOD_W-1:0] periodCnt_ff;
  logic                periodValid_ff;
  logic [PERIOD_W-1:0] expectPeriod;
  logic [PERIOD_W-1:0] cfgPeriod;

  assign cfgPeriod    = PERIOD_W'(mult) * (PERIOD_W'(sbgEffDivisor(cfg)) + 24'h000001);
  assign expectPeriod = cfgPeriod;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      periodCnt_ff <= '0;
    end else if (baudTick || restart) begin
      periodCnt_ff <= 24'h000001;
    end else begin
      periodCnt_ff <= periodCnt_ff + 24'h000001;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      periodValid_ff <= 1'b0;
    end else if (restart) begin
      periodValid_ff <= 1'b0;
    end else if (baudTick) begin
      periodValid_ff <= 1'b1;
    end
  end

  // ==========================================================
  // checks
  a_async_slow_narrow: assert property (@(posedge sys_clk) disable iff (rst)
    baudTick && periodValid_ff && !cfg.syncMode && !cfg.wideDivisor && !cfg.highSpeed
      |-> periodCnt_ff == PERIOD_W'(64) * (PERIOD_W'(divLow_ff) + 24'h000001))
    else $error("async 8-bit low speed period wrong");

  a_async_slow_wide: assert property (@(posedge sys_clk) disable iff (rst)
    baudTick && periodValid_ff && !cfg.syncMode && cfg.wideDivisor && !cfg.highSpeed
      |-> periodCnt_ff == PERIOD_W'(16) * (PERIOD_W'(cfg.divisor) + 24'h000001))
    else $error("async 16-bit low speed period wrong");

  a_sync_period: assert property (@(posedge sys_clk) disable iff (rst)
    baudTick && periodValid_ff && cfg.syncMode
      |-> periodCnt_ff == PERIOD_W'(4) * (PERIOD_W'(sbgEffDivisor(cfg)) + 24'h000001))
    else $error("sync period wrong");

  a_async_fast_rate: assert property (@(posedge sys_clk) disable iff (rst)
    baudTick && periodValid_ff && !cfg.syncMode && cfg.highSpeed
      |-> periodCnt_ff == (cfg.wideDivisor
            ? PERIOD_W'(4) * (PERIOD_W'(cfg.divisor) + 24'h000001)
            : PERIOD_W'(16) * (PERIOD_W'(divLow_ff) + 24'h000001)))
    else $error("async high speed period wrong");

  a_vector_div_zero: assert property (@(posedge sys_clk) disable iff (rst)
    baudTick && periodValid_ff && cfg == sbg_rate_cfg_t'{1'b0, 1'b0, 1'b0, 16'h0000}
      |-> periodCnt_ff == 24'h000040)
    else $error("divisor 0 did not give clock over 64");

  a_vector_div_two: assert property (@(posedge sys_clk) disable iff (rst)
    baudTick && periodValid_ff && !cfg.syncMode && !cfg.wideDivisor && !cfg.highSpeed
      && divLow_ff == 8'h02 |-> periodCnt_ff == 24'h0000c0)
    else $error("divisor 2 did not give clock over 192");

  a_sync_ignores_speed: assert property (@(posedge sys_clk) disable iff (rst)
    cfg.syncMode |-> mult == MULT_FAST)
    else $error("high speed bit affected sync multiplier");

  a_restart_no_tick: assert property (@(posedge sys_clk) disable iff (rst)
    restart |=> !baudTick ##0 timerCount == 16'h0000)
    else $error("divisor write did not restart timer");

  a_idle_flag_read: assert property (@(posedge sys_clk) disable iff (rst)
    busReq.rdStb && busReq.addr == OFS_BAUD_CTRL && !rxActive && !$past(rxActive)
      |=> rdData[BC_IDLE_BIT] == 1'b1)
    else $error("idle flag not reading 1 while receiver idle");

  a_tick_spacing: assert property (@(posedge sys_clk) disable iff (rst)
    baudTick && periodValid_ff |-> periodCnt_ff == expectPeriod)
    else $error("baud tick spacing off");

endmodule : sbg_baud_gen

// ### verification/sbg_baud_gen_bench.sv
// self-checking bench for the serial baud rate generator
// assumes sbg_pkg and the design modules are compiled before this file
`timescale 1ns/10ps
`define CHECK(what, exp, got) begin \
  checksDone++; \
  if ((got) !== (exp)) begin \
    failCount++; \
    $display("Error %s expected %h seen %h", what, exp, got); \
  end \
end
module sbg_baud_gen_bench;
  import sbg_pkg::*;

  logic         sys_clk;
  logic         rst;
  sbg_bus_req_t busReq;
  logic [7:0]   rdData;
  logic         rxActive;
  logic         txShiftEmpty;
  logic [2:0]   rxStatus;
  logic         syncMode;
  logic         baudTick;
  logic [7:0]   baudControl;
  logic [7:0]   txControl;
  logic [7:0]   rxControl;
  logic [7:0]   txW;
  logic [7:0]   rxW;
  logic [7:0]   bcW;
  logic [7:0]   hiW;
  logic [7:0]   loW;
  int           failCount;
  int           checksDone;
  int           seed;

  sbg_baud_gen dut (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .busReq       (busReq),
    .rdData       (rdData),
    .rxActive     (rxActive),
    .txShiftEmpty (txShiftEmpty),
    .rxStatus     (rxStatus),
    .txControl    (txControl),
    .rxControl    (rxControl),
    .baudControl  (baudControl),
    .syncMode     (syncMode),
    .baudTick     (baudTick)
  );

  // ==========================================================
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // verdict and bus tasks
  task automatic printVerdict();
    if (failCount == 0 && checksDone > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : printVerdict

  // one idle cycle before each strobe, so no signal is set twice in a step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    busReq.addr   <= a;
    busReq.wrData <= d;
    busReq.wrStb  <= 1'b1;
    @(posedge sys_clk);
    busReq.wrStb  <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    busReq.addr  <= a;
    busReq.rdStb <= 1'b1;
    @(posedge sys_clk);
    busReq.rdStb <= 1'b0;
    #1 d = rdData;
    @(posedge sys_clk);
    #1 `CHECK("read data idle", 8'h00, rdData)
  endtask : rd

  task automatic waitTick(input int bound, output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (baudTick !== 1'b1 && n < bound);
    if (baudTick !== 1'b1) begin
      failCount++;
      $display("Error baud tick expected 1 seen none");
      printVerdict();
    end
  endtask : waitTick

  // first tick may lag the restart by a cycle or two, later ones are exact
  task automatic checkTicks(input int p);
    int n;
    waitTick(p + 8, n);
    `CHECK("first tick window", 1'b1, (n >= p - 1 && n <= p + 2))
    waitTick(p + 8, n);
    `CHECK("tick period", p, n)
  endtask : checkTicks

  task automatic runRate(input logic [7:0] tx, bc, hi, lo, input int p);
    wr(OFS_TX_CTRL, tx);
    wr(OFS_BAUD_CTRL, bc);
    wr(OFS_DIV_HIGH, hi);
    wr(OFS_DIV_LOW, lo);
    checkTicks(p);
  endtask : runRate

  // ==========================================================
  // expectations
  function automatic int expPeriod(input logic s, h, w, input logic [7:0] hi, lo);
    int m;
    if (s) m = 4;
    else if (!w) m = h ? 16 : 64;
    else m = h ? 4 : 16;
    return m * ((w ? int'({hi, lo}) : int'(lo)) + 1);
  endfunction : expPeriod

  function automatic logic [7:0] expRead(input logic [2:0] a);
    case (a)
      OFS_TX_CTRL:   return (txW & TX_WR_MASK) | (8'(txShiftEmpty) << TX_EMPTY_BIT);
      OFS_RX_CTRL:   return (rxW & RX_WR_MASK) | {5'h00, rxStatus};
      OFS_BAUD_CTRL: return (bcW & BC_WR_MASK) | {1'b0, !rxActive, 6'h00};
      OFS_DIV_HIGH:  return hiW;
      OFS_DIV_LOW:   return loW;
      default:       return 8'h00;
    endcase
  endfunction : expRead

  // ==========================================================
  // main sequence
  initial begin
    int         n;
    logic [7:0] d;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [2:0] a;
    seed = 32'ha0ef;
    failCount = 0;
    checksDone = 0;
    rst = 1'b1;
    busReq = '0;
    rxActive = 1'b0;
    txShiftEmpty = 1'b1;
    rxStatus = 3'h0;
    {txW, rxW, bcW, hiW, loW} = '0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    // out of reset: async, 8-bit, low speed, divisor 0
    waitTick(80, n);
    waitTick(80, n);
    `CHECK("period after reset", 64, n)
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), d);
      `CHECK("reset read", expRead(3'(i)), d)
    end
    // random register traffic, unmapped offsets included
    for (int i = 0; i < 40; i++) begin
      rxActive <= 1'($random(seed));
      txShiftEmpty <= 1'($random(seed));
      rxStatus <= 3'($random(seed));
      repeat (2) @(posedge sys_clk);
      a = 3'($random(seed));
      d = 8'($random(seed));
      if ($random(seed) & 1) begin
        wr(a, d);
        case (a)
          OFS_TX_CTRL:   txW = d;
          OFS_RX_CTRL:   rxW = d;
          OFS_BAUD_CTRL: bcW = d;
          OFS_DIV_HIGH:  hiW = d;
          OFS_DIV_LOW:   loW = d;
          default:       ;
        endcase
        #1 `CHECK("sync mode out", txW[TX_SYNC_BIT], syncMode)
        `CHECK("baud control out", bcW & BC_WR_MASK, baudControl)
        `CHECK("tx control out", txW & TX_WR_MASK, txControl)
        `CHECK("rx control out", rxW & RX_WR_MASK, rxControl)
      end else begin
        rd(a, d);
        `CHECK("register read", expRead(a), d)
      end
    end
    // receiver quiet: idle flag confirmed before the rate is changed
    rxActive <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd(OFS_BAUD_CTRL, d);
    `CHECK("idle before rate change", 1'b1, d[BC_IDLE_BIT])
    // high byte ignored in 8-bit mode
    runRate(8'h00, 8'h00, 8'h05, 8'h00, 64);
    runRate(8'h00, 8'h00, 8'h05, 8'h02, 192);
    // every mode combination twice, random divisors
    for (int i = 0; i < 16; i++) begin
      hi = 8'($random(seed)) & 8'h01;
      lo = 8'($random(seed)) & 8'h0f;
      runRate({3'h0, i[2], 1'b0, i[1], 2'h0}, {4'h0, i[0], 3'h0}, hi, lo,
              expPeriod(i[2], i[1], i[0], hi, lo));
    end
    // low byte write cuts a long count short
    wr(OFS_TX_CTRL, 8'h00);
    wr(OFS_BAUD_CTRL, 8'h00);
    wr(OFS_DIV_LOW, 8'hff);
    repeat (100) @(posedge sys_clk);
    wr(OFS_DIV_LOW, 8'h01);
    checkTicks(128);
    // high byte write does the same in 16-bit mode
    wr(OFS_BAUD_CTRL, 8'h08);
    wr(OFS_DIV_HIGH, 8'h01);
    wr(OFS_DIV_LOW, 8'h00);
    repeat (50) @(posedge sys_clk);
    wr(OFS_DIV_HIGH, 8'h00);
    checkTicks(16);
    // reset in mid-run brings back the narrow power-up rate
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    {txW, rxW, bcW, hiW, loW} = '0;
    waitTick(80, n);
    waitTick(80, n);
    `CHECK("period after second reset", 64, n)
    rd(OFS_BAUD_CTRL, d);
    `CHECK("baud control after reset", expRead(OFS_BAUD_CTRL), d)
    printVerdict();
  end

endmodule : sbg_baud_gen_bench
